//--- core/spe_port.sv
// serial peripheral port, master or slave, with its silicon quirks kept
// assumes control bits from software as levels/pulses on clk_sys,
// and pins from outside, which pass two flops before use
//
// Functional notes
// - disable command ignored while acting as slave
// - extra sck pulse on divisor-one mismatch, only with idle-high clock and phase select 0
// - select0 hold plus fault detect blocks start
// - disabled port drops writes, empty flag stays
// - dma words after disable are lost
// - fault detection enabled may misbehave
`timescale 1ns/1ps
module spe_port
	import spe_pkg::*;
(
	// clock and reset
	input  wire logic                       clk_sys,
	input  wire logic                       resetn,
	// control and configuration
	input  wire logic                       master_mode,
	input  wire logic                       fault_detect_disable,
	input  wire logic                       enable_cmd,
	input  wire logic                       disable_cmd,
	input  wire logic                       soft_reset_bit,
	input  wire logic [`SPE_SELW-1:0]       sel_index,
	input  wire spe_sel_cfg_t [`SPE_NSEL-1:0] sel_cfg,
	// transmit holding, written by the dma channel
	input  wire logic                       tx_wr,
	input  wire logic [`SPE_WORDW-1:0]      tx_data,
	output logic                            tx_holding_empty,
	// received words
	output logic                            rx_valid,
	output logic [`SPE_WORDW-1:0]           rx_data,
	input  wire logic                       rx_ready,
	// status
	output logic                            port_enabled,
	output logic                            mode_fault,
	output logic                            overrun,
	// pins
	input  wire logic                       sck_in,
	output logic                            sck_out,
	output logic                            sck_oe,
	input  wire logic                       mosi_in,
	output logic                            mosi_out,
	output logic                            mosi_oe,
	input  wire logic                       miso_in,
	output logic                            miso_out,
	output logic                            miso_oe,
	input  wire logic                       ss_n_in,
	output logic [`SPE_NSEL-1:0]            cs_n_out,
	output logic                            cs_oe
);
	spe_state_t   q;
	spe_state_t   d;
	spe_sel_cfg_t cfg;
	spe_sel_cfg_t ncfg;
	logic         rx_in_ready;
	logic         start_ok;
	logic         extra_need;
	logic         hold_block;
	logic         half_tick;
	logic         s_rise;
	logic         s_fall;
	logic         s_lead;
	logic         s_samp;
	logic         s_shift;

	////////////////////////////////////////////////////////////////////////////
	// decode helpers
	assign cfg        = sel_cfg[q.cur_sel];
	assign ncfg       = sel_cfg[sel_index];
	assign half_tick  = (q.div_cnt == '0);
	assign hold_block = sel_cfg[0].hold_select_after_transfer
		&& !fault_detect_disable;
	assign start_ok   = master_mode && q.enabled && !q.tx_empty && rx_in_ready
		&& !hold_block && (q.mst == M_IDLE);
	// quirk kept: divisor-one change between selects in this mode
	assign extra_need = q.prev_valid
		&& (q.prev_one != (ncfg.serial_clock_divisor == `SPE_DIV_ONE))
		&& ncfg.clock_idle_level && !ncfg.sample_phase_select;
	assign s_rise  = !q.sck_prev && q.s2.sck;
	assign s_fall  = q.sck_prev && !q.s2.sck;
	assign s_lead  = sel_cfg[0].clock_idle_level ? s_fall : s_rise;
	assign s_samp  = sel_cfg[0].sample_phase_select ? s_lead : (s_rise || s_fall) && !s_lead;
	assign s_shift = (s_rise || s_fall) && !s_samp;

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		d = q;
		d.rx_push  = 1'b0;
		d.s1       = '{sck: sck_in, mosi: mosi_in, miso: miso_in, ss_n: ss_n_in};
		d.s2       = q.s1;
		d.sck_prev = q.s2.sck;
		d.ss_prev  = q.s2.ss_n;

		// enable and disable; slave keeps running
		if (enable_cmd) begin
			d.enabled = 1'b1;
		end else if (disable_cmd && master_mode) begin
			d.enabled = 1'b0;
		end
		// a low select seen as master trips the fault and stops the port
		if (master_mode && !fault_detect_disable && q.enabled && !q.s2.ss_n) begin
			d.mode_fault = 1'b1;
			d.enabled    = 1'b0;
		end

		// master sequencer
		unique case (q.mst)
			M_IDLE: begin
				d.sck_o = ncfg.clock_idle_level;
				if (start_ok) begin
					d.cur_sel    = sel_index;
					d.tx_sh      = q.tx_hold;
					d.tx_empty   = 1'b1;
					d.cs_n       = ~(`SPE_NSEL'(1) << sel_index);
					d.edge_cnt   = '0;
					d.div_cnt    = (ncfg.serial_clock_divisor == '0) ? '0
						: ncfg.serial_clock_divisor - `SPE_DIV_ONE;
					d.prev_valid = 1'b1;
					d.prev_one   = (ncfg.serial_clock_divisor == `SPE_DIV_ONE);
					if (extra_need) begin
						d.mst   = M_EXTRA;
						d.sck_o = !ncfg.clock_idle_level;
					end else begin
						d.mst = M_SHIFT;
					end
				end
			end
			M_EXTRA: begin
				d.div_cnt = q.div_cnt - `SPE_DIV_ONE;
				if (half_tick) begin
					d.sck_o   = cfg.clock_idle_level;
					d.mst     = M_SHIFT;
					d.div_cnt = (cfg.serial_clock_divisor == '0) ? '0
						: cfg.serial_clock_divisor - `SPE_DIV_ONE;
				end
			end
			M_SHIFT: begin
				d.div_cnt = q.div_cnt - `SPE_DIV_ONE;
				if (half_tick) begin
					d.div_cnt  = (cfg.serial_clock_divisor == '0) ? '0
						: cfg.serial_clock_divisor - `SPE_DIV_ONE;
					d.sck_o    = !q.sck_o;
					d.edge_cnt = q.edge_cnt + `SPE_EDGEW'(1);
					// even edges lead; phase bit picks which edge samples
					if ((!q.edge_cnt[0]) == cfg.sample_phase_select) begin
						d.rx_sh = {q.rx_sh[`SPE_WORDW-2:0], q.s2.miso};
					end else if (q.edge_cnt != '0) begin
						d.tx_sh = {q.tx_sh[`SPE_WORDW-2:0], 1'b0};
					end
					if (q.edge_cnt == `SPE_LAST_EDGE) begin
						d.mst = M_DONE;
					end
				end
			end
			M_DONE: begin
				d.rx_word = q.rx_sh;
				d.rx_push = 1'b1;
				d.mst     = M_IDLE;
				if (!cfg.hold_select_after_transfer) begin
					d.cs_n = `SPE_CS_IDLE;
				end
			end
		endcase
		if (!master_mode || !q.enabled) begin
			d.mst  = M_IDLE;
			d.cs_n = `SPE_CS_IDLE;
		end

		// slave shifter on sampled pins, configured by select 0
		if (!master_mode && q.enabled) begin
			if (q.ss_prev && !q.s2.ss_n) begin
				d.sbit = '0;
				if (!q.tx_empty) begin
					d.tx_sh    = q.tx_hold;
					d.tx_empty = 1'b1;
				end
			end else if (!q.s2.ss_n && s_samp) begin
				d.rx_sh = {q.rx_sh[`SPE_WORDW-2:0], q.s2.mosi};
				d.sbit  = q.sbit + `SPE_BITW'(1);
				if (q.sbit == `SPE_LAST_BIT) begin
					d.rx_word = {q.rx_sh[`SPE_WORDW-2:0], q.s2.mosi};
					d.rx_push = 1'b1;
					d.overrun = q.overrun || !rx_in_ready; // slave cannot stall
					if (!q.tx_empty) begin
						d.tx_sh    = q.tx_hold;
						d.tx_empty = 1'b1;
					end
				end
			end else if (!q.s2.ss_n && s_shift
				&& !(q.sbit == '0 && !sel_cfg[0].sample_phase_select)) begin
				d.tx_sh = {q.tx_sh[`SPE_WORDW-2:0], 1'b0};
			end
		end

		// holding write after any load so the new word wins; dropped when off
		if (tx_wr && q.enabled) begin
			d.tx_hold  = tx_data;
			d.tx_empty = 1'b0;
		end // disabled: word lost, flag untouched

		d.drv_master = master_mode && d.enabled;
		d.drv_slave  = !master_mode && d.enabled && !q.s2.ss_n;

		// soft reset returns the state to reset values, except s1 and s2 keep their samples and ss_prev goes low
		if (soft_reset_bit) begin
			d = '0;
			d.tx_empty = 1'b1;
			d.cs_n     = `SPE_CS_IDLE;
			d.s1       = q.s1;
			d.s2       = q.s2;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			q          <= '0;
			q.tx_empty <= 1'b1;
			q.cs_n     <= `SPE_CS_IDLE;
			q.s1.ss_n  <= 1'b1; // select idles high: no false fault after reset
			q.s2.ss_n  <= 1'b1;
			q.ss_prev  <= 1'b1;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// receive buffer; its ready holds off new master transfers
	spe_buffer #(
		.W (`SPE_WORDW),
		.D (`SPE_BUF_DEPTH)
	) u_rx_buf (
		.clk_sys   (clk_sys),
		.resetn    (resetn),
		.clear     (soft_reset_bit),
		.in_valid  (q.rx_push),
		.in_data   (q.rx_word),
		.in_ready  (rx_in_ready),
		.out_valid (rx_valid),
		.out_data  (rx_data),
		.out_ready (rx_ready)
	);

	// outputs straight from state
	assign tx_holding_empty = q.tx_empty;
	assign port_enabled     = q.enabled;
	assign mode_fault       = q.mode_fault;
	assign overrun          = q.overrun;
	assign sck_out          = q.sck_o;
	assign sck_oe           = q.drv_master;
	assign mosi_out         = q.tx_sh[`SPE_WORDW-1];
	assign mosi_oe          = q.drv_master;
	assign miso_out         = q.tx_sh[`SPE_WORDW-1];
	assign miso_oe          = q.drv_slave;
	assign cs_n_out         = q.cs_n;
	assign cs_oe            = q.drv_master;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	a_slave_stays_on: assert property (
		!master_mode && q.enabled && disable_cmd && !soft_reset_bit |=> port_enabled)
		else $error("slave port was disabled");
	a_extra_pulse_out: assert property (
		start_ok && extra_need && !soft_reset_bit
		|=> (q.mst == M_EXTRA && sck_out != cfg.clock_idle_level)
		##[1:256] (q.mst == M_SHIFT && sck_out == cfg.clock_idle_level))
		else $error("missing extra sck pulse");
	a_hold_no_start: assert property (
		hold_block && q.mst == M_IDLE |=> q.mst == M_IDLE)
		else $error("transfer started with select0 hold and fault detect");
	a_off_write_empty: assert property (
		!q.enabled && tx_wr && tx_holding_empty |=> tx_holding_empty)
		else $error("disabled write cleared empty flag");
	a_off_word_lost: assert property (
		!q.enabled && tx_wr && !soft_reset_bit |=> $stable(q.tx_hold))
		else $error("word accepted while disabled");
	a_fault_stops: assert property (
		master_mode && !fault_detect_disable && q.enabled && !q.s2.ss_n
		&& !soft_reset_bit |=> mode_fault && !port_enabled ##1 !sck_oe)
		else $error("mode fault did not stop master");
	a_write_clears: assert property (
		q.enabled && tx_wr && !soft_reset_bit |=> !tx_holding_empty)
		else $error("write did not clear empty flag");
	a_load_sets: assert property (
		start_ok && !tx_wr && !soft_reset_bit |=> tx_holding_empty ##0 q.mst != M_IDLE)
		else $error("shifter load did not set empty flag");

	c_extra_pulse: cover property (q.mst == M_EXTRA);
	c_master_word: cover property (q.rx_push && master_mode);
	c_slave_word: cover property (q.rx_push && !master_mode);
	c_dropped_write: cover property (!q.enabled && tx_wr);
endmodule

//--- core/spe_consts.svh
// constants of the serial port: widths, counts and reset values
// assumes inclusion from the package and from the testbench files
`ifndef SPE_CONSTS_SVH
`define SPE_CONSTS_SVH
`define SPE_NSEL      4
`define SPE_SELW      2
`define SPE_WORDW     8
`define SPE_DIVW      8
`define SPE_EDGEW     4
`define SPE_BITW      3
`define SPE_LAST_EDGE 4'hf
`define SPE_LAST_BIT  3'h7
`define SPE_DIV_ONE   8'h01
`define SPE_BUF_DEPTH 2
`define SPE_CS_IDLE   4'hf
`endif

//--- core/spe_pkg.sv
// types shared by the serial port core
// assumes spe_consts.svh sits on the include path
package spe_pkg;
`include "spe_consts.svh"

	// per-select configuration
	typedef struct packed {
		logic [`SPE_DIVW-1:0] serial_clock_divisor;
		logic                 clock_idle_level;
		logic                 sample_phase_select;
		logic                 hold_select_after_transfer;
	} spe_sel_cfg_t;

	typedef enum logic [1:0] {M_IDLE, M_EXTRA, M_SHIFT, M_DONE} spe_mstate_t;

	// pin samples
	typedef struct packed {
		logic sck;
		logic mosi;
		logic miso;
		logic ss_n;
	} spe_pins_t;

	typedef struct packed {
		spe_pins_t             s1;
		spe_pins_t             s2;
		logic                  sck_prev;
		logic                  ss_prev;
		logic                  enabled;
		logic                  mode_fault;
		logic                  overrun;
		logic [`SPE_WORDW-1:0] tx_hold;
		logic                  tx_empty;
		logic [`SPE_WORDW-1:0] tx_sh;
		logic [`SPE_WORDW-1:0] rx_sh;
		spe_mstate_t           mst;
		logic [`SPE_DIVW-1:0]  div_cnt;
		logic [`SPE_EDGEW-1:0] edge_cnt;
		logic [`SPE_SELW-1:0]  cur_sel;
		logic                  prev_valid;
		logic                  prev_one;
		logic                  sck_o;
		logic                  drv_master;
		logic                  drv_slave;
		logic [`SPE_NSEL-1:0]  cs_n;
		logic [`SPE_BITW-1:0]  sbit;
		logic                  rx_push;
		logic [`SPE_WORDW-1:0] rx_word;
	} spe_state_t;
endpackage

//--- core/spe_buffer.sv
// two-entry receive buffer, head entry held in a register
// assumes one clock; clear is a synchronous one-cycle pulse
`timescale 1ns/1ps
module spe_buffer #(
	parameter int W = 8,
	parameter int D = 2
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         resetn,
	input  wire logic         clear,
	// filling side
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	// draining side
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [D-1:0]        vld;
	} buf_t;

	buf_t q;
	buf_t d;
	logic placed;

	// shift on pop, then drop the new word in the first free slot
	always_comb begin
		d = q;
		placed = 1'b0;
		if (clear) begin
			d.vld = '0;
		end else begin
			if (out_ready && q.vld[0]) begin
				for (int i = 0; i < D - 1; i++) begin
					d.mem[i] = q.mem[i + 1];
					d.vld[i] = q.vld[i + 1];
				end
				d.mem[D-1] = '0;
				d.vld[D-1] = 1'b0;
			end
			if (in_valid && !q.vld[D-1]) begin
				for (int i = 0; i < D; i++) begin
					if (!placed && !d.vld[i]) begin
						d.mem[i] = in_data;
						d.vld[i] = 1'b1;
						placed = 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign in_ready  = !q.vld[D-1]; // full only when last slot taken
	assign out_valid = q.vld[0];
	assign out_data  = q.mem[0];
endmodule

//--- testbench/spe_ext_dev.sv
// external serial device: a slave when the port leads, a master otherwise
// assumes pins wired straight across; data lines have no pull resistor
`timescale 1ns/1ps
`include "spe_consts.svh"
module spe_ext_dev (
	// port acting as master
	input  wire logic [`SPE_NSEL-1:0] cs_n_out,
	input  wire logic                 sck_out,
	input  wire logic                 mosi_out,
	output logic                      miso_in,
	// port acting as slave
	input  wire logic                 miso_out,
	output logic                      sck_in,
	output logic                      mosi_in,
	output logic                      ss_n_in
);
	logic [7:0] reply = 8'h3c;
	logic [7:0] got;
	logic [7:0] slv_got;
	logic [7:0] sh;
	logic       sel;
	int         falls;

	assign sel = (cs_n_out != `SPE_CS_IDLE);

	// idle levels; the serial clock stands still outside frames
	initial begin
		sck_in = 1'b0;
		mosi_in = 1'b0;
		ss_n_in = 1'b1;
		miso_in = 1'b0;
	end

	// reply msb on select; released line flips so no level is trusted
	always @(sel) begin
		if (sel) begin
			sh = reply;
			falls = 0; // count kept after deselect for the bench to read
		end
		miso_in = sel ? sh[7] : ~miso_in;
	end

	// capture on rising edge, next reply bit after each falling edge
	always @(posedge sck_out) if (sel) got = {got[6:0], mosi_out};
	// one step late, so an edge in the step that selects still counts
	always @(negedge sck_out) begin
		#1;
		if (sel) begin
			falls++;
			sh = {sh[6:0], 1'b0};
			miso_in = sh[7];
		end
	end

	////////////////////////////////////////////////////////////////
	// one frame as master, 800 ns per bit, msb first
	task automatic send(input logic [7:0] b);
		ss_n_in = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			mosi_in = b[i];
			#400 sck_in = 1'b1;
			slv_got = {slv_got[6:0], miso_out};
			#400 sck_in = 1'b0;
		end
		#400 ss_n_in = 1'b1;
		mosi_in = ~mosi_in;
		#800; // select seen high before any next frame
	endtask

	task automatic hold_sel(input logic v);
		ss_n_in = v;
	endtask
endmodule

//--- testbench/tb_top.sv
// bench for the serial port: scenarios as tasks, one verdict at the end
// assumes spe_pkg compiled first and the external device model alongside
`timescale 1ns/1ps
`include "spe_consts.svh"
module tb_top
	import spe_pkg::*;
;
	// control, configuration and status
	logic clk_sys = 1'b0;
	logic resetn, master_mode, fault_detect_disable, enable_cmd, disable_cmd;
	logic soft_reset_bit, tx_wr, rx_ready, tx_holding_empty, rx_valid;
	logic port_enabled, mode_fault, overrun;
	logic [`SPE_SELW-1:0]  sel_index;
	logic [`SPE_WORDW-1:0] tx_data, rx_data;
	spe_sel_cfg_t [`SPE_NSEL-1:0] sel_cfg;
	// pins
	logic sck_in, sck_out, sck_oe, mosi_in, mosi_out, miso_in, ss_n_in, cs_oe;
	logic mosi_oe, miso_out, miso_oe;
	logic [`SPE_NSEL-1:0] cs_n_out;
	int   err_total, total_checks, cycles;

	spe_port dut (
		.clk_sys, .resetn, .master_mode, .fault_detect_disable, .enable_cmd,
		.disable_cmd, .soft_reset_bit, .sel_index, .sel_cfg, .tx_wr, .tx_data,
		.tx_holding_empty, .rx_valid, .rx_data, .rx_ready, .port_enabled,
		.mode_fault, .overrun, .sck_in, .sck_out, .sck_oe, .mosi_in, .mosi_out,
		.mosi_oe, .miso_in, .miso_out, .miso_oe, .ss_n_in, .cs_n_out, .cs_oe
	);
	spe_ext_dev dev (
		.cs_n_out, .sck_out, .mosi_out, .miso_in, .miso_out, .sck_in, .mosi_in, .ss_n_in
	);

	always #50 clk_sys = ~clk_sys;

	// hang guard, far above the thousand or so cycles the run needs
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			wrap_up();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// held over one edge, then a gap so no signal is set twice at once
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
		cyc(1);
	endtask
	function automatic logic probe(input int k);
		return k == 0 ? (cs_n_out == `SPE_CS_IDLE) : rx_valid;
	endfunction
	task automatic wait_for(input int k, input logic v, input int lim);
		for (int n = 0; n < lim && probe(k) !== v; n++)
			cyc(1);
		if (probe(k) !== v) begin
			err_total++;
			$display("ERROR %0t: wait ran out", $time);
		end
	endtask
	task automatic frame(input logic [7:0] d);
		tx_data = d;
		pulse(tx_wr);
		wait_for(0, 1'b0, 30);
		wait_for(0, 1'b1, 600);
		wait_for(1, 1'b1, 30);
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_master_byte();
		tx_data = 8'h5a;
		pulse(tx_wr);
		chk(tx_holding_empty, 1'b1);
		chk(cs_n_out, 4'hf);
		pulse(enable_cmd);
		chk({port_enabled, cs_oe, sck_oe, mosi_oe}, 4'hf);
		frame(8'hc3);
		chk(dev.got, 8'hc3);
		chk(rx_data, 8'h3c);
		chk(tx_holding_empty, 1'b1);
		pulse(rx_ready);
		chk(rx_valid, 1'b0);
	endtask

	task automatic t_hold_block();
		sel_cfg[0].hold_select_after_transfer = 1'b1;
		fault_detect_disable = 1'b0;
		tx_data = 8'h81;
		pulse(tx_wr);
		cyc(200);
		chk(tx_holding_empty, 1'b0);
		chk(cs_n_out, 4'hf);
		fault_detect_disable = 1'b1;
		wait_for(0, 1'b0, 30);
		chk(cs_n_out, 4'he);
		wait_for(1, 1'b1, 400);
		chk(cs_n_out, 4'he);
		pulse(rx_ready);
		pulse(disable_cmd);
		chk({port_enabled, cs_n_out}, 5'h0f);
		sel_cfg[0].hold_select_after_transfer = 1'b0;
	endtask

	task automatic t_disable_dma();
		pulse(enable_cmd);
		tx_data = 8'h11;
		pulse(tx_wr);
		cyc(10);                               // no more writes, then disable
		pulse(disable_cmd);
		chk(port_enabled, 1'b0);
		for (int i = 0; i < 3; i++) begin
			tx_data = 8'h20 + 8'(i);
			pulse(tx_wr);
			chk(tx_holding_empty, 1'b1);
		end
		pulse(enable_cmd);
		cyc(40);
		chk(cs_n_out, 4'hf);
		chk(tx_holding_empty, 1'b1);
		pulse(soft_reset_bit);
	endtask

	task automatic t_extra_pulse();
		pulse(enable_cmd);
		sel_cfg[1] = {8'h01, 1'b1, 1'b0, 1'b0};
		sel_cfg[2] = {8'h04, 1'b1, 1'b0, 1'b0};
		sel_index = 2'h2;
		frame(8'h0f);
		chk(dev.falls[7:0], 8'h08);
		pulse(rx_ready);
		sel_index = 2'h1;
		frame(8'hf0);
		chk(dev.falls[7:0], 8'h09);
		pulse(rx_ready);
		sel_index = 2'h0;
	endtask

	task automatic t_fault();
		fault_detect_disable = 1'b0;
		pulse(soft_reset_bit);
		pulse(enable_cmd);
		dev.hold_sel(1'b0);
		cyc(8);
		chk({mode_fault, port_enabled}, 2'h2);
		dev.hold_sel(1'b1);
		fault_detect_disable = 1'b1;
		pulse(soft_reset_bit);
		chk(mode_fault, 1'b0);
	endtask

	task automatic t_slave();
		master_mode = 1'b0;
		pulse(enable_cmd);
		pulse(disable_cmd);
		chk(port_enabled, 1'b1);
		tx_data = 8'ha5;
		pulse(tx_wr);
		dev.send(8'h96);
		wait_for(1, 1'b1, 30);
		chk(rx_data, 8'h96);
		chk(dev.slv_got, 8'ha5);
		chk({miso_oe, mosi_oe}, 2'h0);
		dev.send(8'h3e);
		dev.send(8'h77);
		cyc(5);
		chk({overrun, rx_data}, 9'h196);
		pulse(rx_ready);
		wait_for(1, 1'b1, 5);
		chk(rx_data, 8'h3e);
		pulse(rx_ready);
		chk(rx_valid, 1'b0);
		pulse(soft_reset_bit);
		chk({port_enabled, overrun}, 2'h0);
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// reset for 12 cycles, then the scenarios in turn
	initial begin
		{resetn, enable_cmd, disable_cmd, soft_reset_bit, tx_wr, rx_ready} = 6'h0;
		{master_mode, fault_detect_disable} = 2'h3; // fault detect off first
		sel_index = 2'h0;
		tx_data = 8'h00;
		for (int i = 0; i < `SPE_NSEL; i++)
			sel_cfg[i] = {8'h08, 1'b0, 1'b1, 1'b0}; // equal divisors
		cyc(12);
		resetn = 1'b1;
		cyc(1);
		chk({tx_holding_empty, port_enabled, cs_oe, cs_n_out}, 7'h4f);
		t_master_byte();
		t_hold_block();
		t_disable_dma();
		t_extra_pulse();
		t_fault();
		t_slave();
		wrap_up();
	end
endmodule
